// [pkg/swt_pkg.sv]
// Contract
// RQ1: Wake counter clocked from internal RC default
// RQ2: Wake-up repeats every period, not one-shot
// RQ3: Counts only if enable set entering sleep
// RQ4: Expiry raises interrupt only when enabled
// RQ5: Host reads both status registers after interrupt
// RQ6: Live 16-bit count readable, counting undisturbed
// RQ7: Period from exponent, divider and mantissa
// RQ8: Host uses divider only for finer resolution
// RQ9: Interrupt output driven low on expiry
// RQ10: Expiry with interrupt enabled starts crystal
// RQ11: Pin signals expiry, state held otherwise
// RQ12: Crystal select turns pin zero into input
// RQ13: Crystal select moves all timing to crystal
// RQ14: Three pins carry selectable internal functions
// RQ15: Shutdown pulls all three pins low
// RQ16: Pins one, two decode like pin zero
// RQ17: Code zero gives reset, inverse, host clock
// RQ18: Host keeps converter off pins in sleep
// RQ19: Counter restarts on sleep entry and expiry
package swt_pkg;
  // Register offsets
  localparam logic [6:0] OFS_IRQ_STAT1   = 7'h03;
  localparam logic [6:0] OFS_IRQ_STAT2   = 7'h04;
  localparam logic [6:0] OFS_IRQ_EN2     = 7'h06;
  localparam logic [6:0] OFS_OP_CTRL1    = 7'h07;
  localparam logic [6:0] OFS_PIN0_CFG    = 7'h0b;
  localparam logic [6:0] OFS_PIN1_CFG    = 7'h0c;
  localparam logic [6:0] OFS_PIN2_CFG    = 7'h0d;
  localparam logic [6:0] OFS_IO_PORT_CFG = 7'h0e;
  localparam logic [6:0] OFS_WAKE_EXPDIV = 7'h14;
  localparam logic [6:0] OFS_WAKE_MANT_H = 7'h15;
  localparam logic [6:0] OFS_WAKE_MANT_L = 7'h16;
  localparam logic [6:0] OFS_WAKE_CNT_H  = 7'h17;
  localparam logic [6:0] OFS_WAKE_CNT_L  = 7'h18;
  // Reset values
  localparam logic [7:0] RST_IRQ_EN2  = 8'h03;
  localparam logic [7:0] RST_OP_CTRL1 = 8'h01;
  localparam logic [7:0] RST_CFG      = 8'h00;
  // Field positions
  localparam int BIT_WAKE_IRQ    = 3;  // wake status / enable in 04h, 06h
  localparam int BIT_WAKE_EN     = 5;  // wake timer enable in 07h
  localparam int BIT_XTAL_SEL    = 4;  // ext_low_freq_crystal_select in 07h
  localparam int FLD_EXP_LSB     = 2;  // exponent [5:2] in 14h
  localparam int FLD_DIV_LSB     = 0;  // divider [1:0] in 14h
  localparam int FLD_FUNC_LSB    = 0;  // pin function [4:0]
  // Pin function codes
  localparam logic [4:0] FUNC_DEFAULT    = 5'h00;
  localparam logic [4:0] FUNC_WAKE_TIMER = 5'h01;
  localparam logic [4:0] FUNC_IRQ        = 5'h02;
  localparam logic [4:0] FUNC_HOST_CLK   = 5'h03;
  // Timing: base unit of the period is four low-frequency ticks
  localparam longint CLK_HZ      = 200_000_000;
  localparam longint LF_HZ       = 32_768;
  localparam int     RC_DIV_CYC  = int'(CLK_HZ / LF_HZ);
  localparam int     PERIOD_BASE = 4;
endpackage

// [rtl/swt_lf_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_lf_tick #(
  parameter int DIV_CYC = swt_pkg::RC_DIV_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Source select and crystal pin
  input  wire logic xtal_sel_i,
  input  wire logic xtal_pin_i,
  // Low-frequency tick
  output logic      tick_o
);
  import swt_pkg::*;

  localparam int W = $clog2(DIV_CYC + 1);
  localparam logic [W-1:0] DIV_LAST = W'(DIV_CYC - 1);

  logic [W-1:0] rc_cnt_q;
  logic         xtal_prev_q;

  // Internal RC stand-in: free divider from the system clock
  always_ff @(posedge clk_i) begin
    if (srst_i || rc_cnt_q == DIV_LAST) begin
      rc_cnt_q <= '0;
    end else begin
      rc_cnt_q <= rc_cnt_q + 1'b1;
    end
  end

  // Crystal edge history
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_prev_q <= xtal_pin_i;
    end
  end

  // Tick source; RC unless the crystal is selected
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_o <= 1'b0;
    end else if (xtal_sel_i) begin
      // RQ13: crystal drives timing
      tick_o <= xtal_pin_i & ~xtal_prev_q;
    end else begin
      // RQ1: RC tick default
      tick_o <= (rc_cnt_q == DIV_LAST);
    end
  end
endmodule
`default_nettype wire

// [rtl/swt_top.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_top #(
  parameter int RC_DIV = swt_pkg::RC_DIV_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       SRST_I,
  // Register port
  input  wire logic [6:0] REG_ADDR_I,
  input  wire logic       REG_WE_I,
  input  wire logic       REG_RE_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  // Operating mode
  input  wire logic       SLEEP_I,
  input  wire logic       SHUTDOWN_I,
  input  wire logic       HOST_CLK_I,
  // Wake outputs
  output logic            INTERRUPT_REQUEST_OUT_LOW_O,
  output logic            XTAL_START_O,
  output logic            LF_TICK_O,
  // General pins
  input  wire logic [2:0] PIN_I,
  output logic      [2:0] PIN_O,
  output logic      [2:0] PIN_OE_O
);
  import swt_pkg::*;

  logic [7:0]  irq_en2_q;
  logic [7:0]  op_ctrl1_q;
  logic [7:0]  pin_cfg_q [3];
  logic [7:0]  io_port_cfg_q;
  logic [7:0]  wake_expdiv_q;
  logic [15:0] wake_mant_q;
  logic [15:0] wake_count_q;
  logic [17:0] presc_q;
  logic        wake_stat_q;
  logic        armed_q;
  logic        sleep_prev_q;
  logic        pin_wake_q;
  logic        por_q;
  logic        lf_tick;
  logic        sleep_entry;
  logic        unit_done;
  logic        expire;
  logic        wake_irq_en;
  logic        xtal_sel;
  logic [17:0] presc_lim;

  // Prescale length in ticks: four shifted up by exponent, down by divider
  function automatic logic [17:0] unit_ticks(input logic [3:0] r, input logic [1:0] d);
    logic [17:0] v;
    v = (18'(PERIOD_BASE) << r) >> d;
    return (v == 18'h0) ? 18'h1 : v;
  endfunction

  // Register write decode, shared by all write processes
  function automatic logic wr_hit(input logic [6:0] a, input logic we, input logic [6:0] ofs);
    return we && (a == ofs);
  endfunction

  assign wake_irq_en = irq_en2_q[BIT_WAKE_IRQ];
  assign xtal_sel    = op_ctrl1_q[BIT_XTAL_SEL];
  // RQ7: exponent and divider shape the unit
  assign presc_lim   = unit_ticks(wake_expdiv_q[FLD_EXP_LSB +: 4], wake_expdiv_q[FLD_DIV_LSB +: 2]);
  assign sleep_entry = SLEEP_I & ~sleep_prev_q;
  assign unit_done   = armed_q & lf_tick & (presc_q + 18'h1 >= presc_lim);
  // RQ7: mantissa sets unit count; zero behaves as one
  assign expire      = unit_done & (wake_count_q + 16'h1 >= wake_mant_q);

  // Tick source select
  swt_lf_tick #(
    .DIV_CYC (RC_DIV)
  ) u_tick (
    .clk_i      (CLOCK_I),
    .srst_i     (SRST_I),
    .xtal_sel_i (xtal_sel),
    .xtal_pin_i (PIN_I[0]),
    .tick_o     (lf_tick)
  );

  // Control and period registers
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      irq_en2_q     <= RST_IRQ_EN2;
      op_ctrl1_q    <= RST_OP_CTRL1;
      io_port_cfg_q <= RST_CFG;
      wake_expdiv_q <= RST_CFG;
      wake_mant_q   <= {RST_CFG, RST_CFG};
    end else begin
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_IRQ_EN2))     irq_en2_q          <= REG_WDATA_I;
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_OP_CTRL1))    op_ctrl1_q         <= REG_WDATA_I;
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_IO_PORT_CFG)) io_port_cfg_q      <= REG_WDATA_I;
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_WAKE_EXPDIV)) wake_expdiv_q      <= REG_WDATA_I;
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_WAKE_MANT_H)) wake_mant_q[15:8]  <= REG_WDATA_I;
      if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_WAKE_MANT_L)) wake_mant_q[7:0]   <= REG_WDATA_I;
    end
  end

  // Pin configuration registers, one per pin
  for (genvar p = 0; p < 3; p++) begin : g_cfg
    always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
        pin_cfg_q[p] <= RST_CFG;
      end else if (wr_hit(REG_ADDR_I, REG_WE_I, OFS_PIN0_CFG + 7'(p))) begin
        pin_cfg_q[p] <= REG_WDATA_I;
      end
    end
  end

  // Sleep edge and power-on marker
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sleep_prev_q <= 1'b0;
      por_q        <= 1'b1;
    end else begin
      sleep_prev_q <= SLEEP_I;
      por_q        <= 1'b0;
    end
  end

  // Arming: enable is sampled only at sleep entry
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || !SLEEP_I) begin
      armed_q <= 1'b0;
    end else if (sleep_entry) begin
      // RQ3: enable checked entering sleep
      armed_q <= op_ctrl1_q[BIT_WAKE_EN];
    end
  end

  // Prescaler and live count
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      presc_q      <= '0;
      wake_count_q <= '0;
    end else if (sleep_entry || expire) begin
      // RQ19: restart from zero
      presc_q      <= '0;
      wake_count_q <= '0;
    end else if (unit_done) begin
      presc_q      <= '0;
      wake_count_q <= wake_count_q + 16'h1;
    end else if (armed_q && lf_tick) begin
      presc_q      <= presc_q + 18'h1;
    end
  end

  // Sticky wake status, cleared by reading its register; set wins
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      wake_stat_q <= 1'b0;
    end else if (expire) begin
      // RQ2: every expiry sets it again
      wake_stat_q <= 1'b1;
    end else if (REG_RE_I && REG_ADDR_I == OFS_IRQ_STAT2) begin
      // RQ5: host read clears status
      wake_stat_q <= 1'b0;
    end
  end

  // Interrupt pin, active low
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      INTERRUPT_REQUEST_OUT_LOW_O <= 1'b1;
    end else begin
      // RQ4: gated by the enable
      // RQ9: low while status and enable
      INTERRUPT_REQUEST_OUT_LOW_O <= ~((wake_stat_q | expire) & wake_irq_en);
    end
  end

  // Crystal start request, held until the next sleep entry
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || sleep_entry) begin
      XTAL_START_O <= 1'b0;
    end else if (expire && wake_irq_en) begin
      // RQ10: wake the main crystal
      XTAL_START_O <= 1'b1;
    end
  end

  // Pin wake level; no state change, host decides what follows
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || sleep_entry) begin
      pin_wake_q <= 1'b0;
    end else if (expire && !wake_irq_en) begin
      // RQ11: pin-only signalling
      pin_wake_q <= 1'b1;
    end
  end

  // Tick out for low duty cycle timing
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      LF_TICK_O <= 1'b0;
    end else begin
      // RQ13: same source as the timer
      LF_TICK_O <= lf_tick;
    end
  end

  // Read mux; count is sampled, never disturbed
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RE_I) begin
      unique case (REG_ADDR_I)
        OFS_IRQ_STAT2:   REG_RDATA_O <= 8'(wake_stat_q) << BIT_WAKE_IRQ;
        OFS_IRQ_EN2:     REG_RDATA_O <= irq_en2_q;
        OFS_OP_CTRL1:    REG_RDATA_O <= op_ctrl1_q;
        OFS_PIN0_CFG:    REG_RDATA_O <= pin_cfg_q[0];
        OFS_PIN1_CFG:    REG_RDATA_O <= pin_cfg_q[1];
        OFS_PIN2_CFG:    REG_RDATA_O <= pin_cfg_q[2];
        OFS_IO_PORT_CFG: REG_RDATA_O <= io_port_cfg_q;
        OFS_WAKE_EXPDIV: REG_RDATA_O <= wake_expdiv_q;
        OFS_WAKE_MANT_H: REG_RDATA_O <= wake_mant_q[15:8];
        OFS_WAKE_MANT_L: REG_RDATA_O <= wake_mant_q[7:0];
        // RQ6: live count readout
        OFS_WAKE_CNT_H:  REG_RDATA_O <= wake_count_q[15:8];
        OFS_WAKE_CNT_L:  REG_RDATA_O <= wake_count_q[7:0];
        default:         REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // Pin function mux, one per pin
  for (genvar p = 0; p < 3; p++) begin : g_pin
    logic [4:0] func;
    logic       dflt;
    assign func = pin_cfg_q[p][FLD_FUNC_LSB +: 5];
    // RQ17: per-pin default function
    assign dflt = (p == 0) ? por_q : (p == 1) ? ~por_q : HOST_CLK_I;
    always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
        PIN_O[p]    <= 1'b0;
        PIN_OE_O[p] <= 1'b1;
      end else if (SHUTDOWN_I) begin
        // RQ15: shutdown drives low
        PIN_O[p]    <= 1'b0;
        PIN_OE_O[p] <= 1'b1;
      end else if (p == 0 && xtal_sel) begin
        // RQ12: pin zero hands over to the crystal
        PIN_O[p]    <= 1'b0;
        PIN_OE_O[p] <= 1'b0;
      end else begin
        // RQ14: selectable function
        // RQ16: identical decode beyond code zero
        PIN_OE_O[p] <= 1'b1;
        unique case (func)
          FUNC_DEFAULT:    PIN_O[p] <= dflt;
          FUNC_WAKE_TIMER: PIN_O[p] <= pin_wake_q;
          FUNC_IRQ:        PIN_O[p] <= INTERRUPT_REQUEST_OUT_LOW_O;
          FUNC_HOST_CLK:   PIN_O[p] <= HOST_CLK_I;
          default:         PIN_O[p] <= 1'b0;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  sequence s_entry_disabled;
    sleep_entry && !op_ctrl1_q[BIT_WAKE_EN];
  endsequence
  sequence s_idle_sleep;
    (SLEEP_I && !expire)[*4];
  endsequence

  arm_on_entry_a: assert property (s_entry_disabled |=> !armed_q) // RQ3
    else $error("timer armed without enable");
  no_expire_idle_a: assert property (s_entry_disabled ##1 s_idle_sleep |-> wake_count_q == 16'h0) // RQ3
    else $error("count moved while disarmed");
  irq_low_a: assert property (expire && wake_irq_en |=> !INTERRUPT_REQUEST_OUT_LOW_O) // RQ9
    else $error("interrupt not asserted on expiry");
  irq_gated_a: assert property (!wake_irq_en && $stable(wake_irq_en) |=> INTERRUPT_REQUEST_OUT_LOW_O) // RQ4
    else $error("interrupt with enable off");
  xtal_start_a: assert property (expire && wake_irq_en && !sleep_entry |=> XTAL_START_O) // RQ10
    else $error("crystal not started");
  restart_zero_a: assert property (expire |=> wake_count_q == 16'h0 && presc_q == 18'h0) // RQ19
    else $error("counter not restarted");
  count_step_a: assert property (unit_done && !expire && !sleep_entry
                                 |=> wake_count_q == $past(wake_count_q) + 16'h1) // RQ6
    else $error("count did not advance");
  shutdown_low_a: assert property (SHUTDOWN_I |=> PIN_O == 3'h0 && PIN_OE_O == 3'h7) // RQ15
    else $error("pins not low in shutdown");
  xtal_pin_a: assert property (xtal_sel && !SHUTDOWN_I |=> !PIN_OE_O[0]) // RQ12
    else $error("pin zero still driven");
  status_sticky_a: assert property (expire |=> wake_stat_q) // RQ2
    else $error("status lost");
  pin_wake_a: assert property (expire && !wake_irq_en && !sleep_entry |=> pin_wake_q) // RQ11
    else $error("pin wake not set");
endmodule
`default_nettype wire

// [tb/swt_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_host_model (
  // Clock and interrupt line
  input  wire logic       clk_i,
  input  wire logic       irq_low_i,
  // Register port
  output logic      [6:0] addr_o,
  output logic            we_o,
  output logic            re_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  import swt_pkg::*;
  // Bus idle from time zero
  initial begin
    addr_o = 7'h00;
    we_o = 1'b0;
    re_o = 1'b0;
    wdata_o = 8'h00;
  end
  // One-cycle write strobe; data is scrambled afterwards so stale bytes are not trusted
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    we_o = 1'b1;
    @(negedge clk_i);
    we_o = 1'b0;
    wdata_o = ~d;
  endtask
  // Read data is registered at the taking edge, settled by the next falling edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    re_o = 1'b1;
    @(negedge clk_i);
    re_o = 1'b0;
    d = rdata_i;
  endtask
  // read both status
  // Interrupt service; the second read also clears the wake status
  task automatic service(output logic [7:0] st2);
    logic [7:0] st1;
    rd(OFS_IRQ_STAT1, st1);
    rd(OFS_IRQ_STAT2, st2);
  endtask
endmodule
`default_nettype wire

// [tb/test_sleep_wakeup_timer_and_pin_config.sv]
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wakeup_timer_and_pin_config;
  import swt_pkg::*;
  // Short divider keeps low-frequency periods to a few cycles
  localparam int DIV = 4;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       sleep = 1'b0;
  logic       shut = 1'b0;
  logic       hclk = 1'b0;
  logic [2:0] pin_in = 3'b000;
  wire  [6:0] addr;
  wire        we;
  wire        re;
  wire  [7:0] wdata;
  logic [7:0] rdata;
  logic       irq_low;
  logic       xtal;
  logic       lftick;
  logic [2:0] pin_o;
  logic [2:0] pin_oe;
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc = 0;
  // Period table: exponent/divider byte, mantissa, expected ticks
  logic [7:0] p_ed [4] = '{8'h00, 8'h08, 8'h05, 8'h03};
  logic [7:0] p_m  [4] = '{8'h03, 8'h01, 8'h05, 8'h09};
  int         p_t  [4] = '{12, 16, 20, 9};
  logic [4:0] codes [4] = '{FUNC_WAKE_TIMER, FUNC_HOST_CLK, FUNC_IRQ, 5'h1f};
  logic [2:0] c_exp [4] = '{3'b111, 3'b111, 3'b111, 3'b000};
  logic [6:0] zofs [7] = '{OFS_PIN0_CFG, OFS_PIN1_CFG, OFS_PIN2_CFG, OFS_IO_PORT_CFG,
                           OFS_WAKE_EXPDIV, OFS_WAKE_MANT_H, OFS_WAKE_MANT_L};

  // Clock and cycle count
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  swt_top #(.RC_DIV(DIV)) dut_u (
    .CLOCK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WE_I(we), .REG_RE_I(re),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SLEEP_I(sleep), .SHUTDOWN_I(shut),
    .HOST_CLK_I(hclk), .INTERRUPT_REQUEST_OUT_LOW_O(irq_low), .XTAL_START_O(xtal),
    .LF_TICK_O(lftick), .PIN_I(pin_in), .PIN_O(pin_o), .PIN_OE_O(pin_oe)
  );
  swt_host_model host_u (
    .clk_i(clk), .irq_low_i(irq_low), .addr_o(addr), .we_o(we), .re_o(re),
    .wdata_o(wdata), .rdata_i(rdata)
  );

  // Comparisons
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    check8(d, exp);
  endtask
  // Bounded wait; a miss shows up in the following range check
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_low !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Counts tick pulses; half > 0 also toggles the crystal pin
  task automatic count_ticks(input int ncyc, input int half, output int k);
    k = 0;
    for (int i = 0; i < ncyc; i++) begin
      @(negedge clk);
      if (half > 0 && i % half == 0) pin_in[0] = ~pin_in[0];
      k += int'(lftick);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    logic [7:0] c1, c2, st;
    int         t0, t1, k;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    rd_chk(OFS_IRQ_EN2, RST_IRQ_EN2);
    rd_chk(OFS_OP_CTRL1, RST_OP_CTRL1);
    for (int i = 0; i < 7; i++) rd_chk(zofs[i], RST_CFG);
    rd_chk(7'h7f, 8'h00);
    // Default codes: reset marker gone, inverse high, host clock passed
    for (int h = 0; h < 2; h++) begin
      hclk = h[0];
      repeat (2) @(negedge clk);
      check8({5'h0, pin_o}, {5'h0, h[0], 2'b10});
    end
    check8({5'h0, pin_oe}, 8'h07);
    host_u.wr(OFS_WAKE_MANT_H, 8'ha5);
    rd_chk(OFS_WAKE_MANT_H, 8'ha5);
    count_ticks(400, 0, k);
    check_rng(k, 400 / DIV - 1, 400 / DIV + 1);
    // Interrupt path across the period table
    host_u.wr(OFS_WAKE_MANT_H, 8'h00);
    host_u.wr(OFS_IRQ_EN2, 8'h0b);
    host_u.wr(OFS_OP_CTRL1, 8'h21);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(OFS_WAKE_EXPDIV, p_ed[i]);
      host_u.wr(OFS_WAKE_MANT_L, p_m[i]);
      sleep = 1'b1;
      t0 = cyc;
      wait_irq();
      check_rng(cyc - t0, p_t[i] * DIV - 5, p_t[i] * DIV + 8);
      check8({7'h0, xtal}, 8'h01);
      host_u.service(st);
      check8({7'h0, st[BIT_WAKE_IRQ]}, 8'h01);
      repeat (2) @(negedge clk);
      check8({7'h0, irq_low}, 8'h01);
      sleep = 1'b0;
      @(negedge clk);
    end
    // Live count, restart on expiry, repeat period of 160 ticks
    host_u.wr(OFS_WAKE_EXPDIV, 8'h00);
    host_u.wr(OFS_WAKE_MANT_L, 8'h28);
    sleep = 1'b1;
    t0 = cyc;
    repeat (100) @(negedge clk);
    host_u.rd(OFS_WAKE_CNT_L, c1);
    repeat (200) @(negedge clk);
    host_u.rd(OFS_WAKE_CNT_L, c2);
    check8({7'h0, c2 > c1}, 8'h01);
    rd_chk(OFS_WAKE_CNT_H, 8'h00);
    wait_irq();
    t1 = cyc;
    check_rng(t1 - t0, 160 * DIV - 5, 160 * DIV + 8);
    host_u.rd(OFS_WAKE_CNT_L, c2);
    check8({7'h0, c2 < c1}, 8'h01);
    host_u.service(st);
    // Line is still low one edge after the clearing read
    repeat (2) @(negedge clk);
    wait_irq();
    check_rng(cyc - t1, 160 * DIV - 5, 160 * DIV + 8);
    host_u.service(st);
    sleep = 1'b0;
    // Timer enable clear: no expiry at all
    host_u.wr(OFS_OP_CTRL1, 8'h01);
    host_u.wr(OFS_WAKE_MANT_L, 8'h03);
    sleep = 1'b1;
    repeat (200) @(negedge clk);
    check8({7'h0, irq_low}, 8'h01);
    sleep = 1'b0;
    // Interrupt disabled, expiry shown on pin one
    host_u.wr(OFS_IRQ_EN2, 8'h03);
    host_u.wr(OFS_OP_CTRL1, 8'h21);
    host_u.wr(OFS_PIN1_CFG, {3'h0, FUNC_WAKE_TIMER});
    // Let pin one leave its inverse reset level first
    repeat (2) @(negedge clk);
    sleep = 1'b1;
    t0 = cyc;
    while (pin_o[1] !== 1'b1 && cyc - t0 < 3000) @(negedge clk);
    check_rng(cyc - t0, 12 * DIV - 5, 12 * DIV + 9);
    repeat (100) @(negedge clk);
    check8({6'h0, pin_o[1], irq_low}, 8'h03);
    sleep = 1'b0;
    hclk = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(OFS_PIN0_CFG, {3'h0, codes[i]});
      host_u.wr(OFS_PIN1_CFG, {3'h0, codes[i]});
      host_u.wr(OFS_PIN2_CFG, {3'h0, codes[i]});
      repeat (2) @(negedge clk);
      check8({5'h0, pin_o}, {5'h0, c_exp[i]});
    end
    shut = 1'b1;
    repeat (2) @(negedge clk);
    check8({2'h0, pin_oe, pin_o}, 8'h38);
    shut = 1'b0;
    // Crystal select frees pin zero and becomes the tick source
    host_u.wr(OFS_OP_CTRL1, 8'h11);
    repeat (2) @(negedge clk);
    check8({7'h0, pin_oe[0]}, 8'h00);
    count_ticks(480, 12, k);
    check_rng(k, 19, 21);
    print_verdict();
  end
endmodule
`default_nettype wire
